// file: ref_cfg_pkg.sv
package ref_cfg_pkg;

    // Byte offsets on the management port
    localparam logic [7:0] OFS_SECOND_REF_PERIOD_LIMITS = 8'h4c;
    localparam logic [7:0] OFS_PLL_SETUP = 8'h4f;
    localparam logic [7:0] OFS_SYNTH_BASE_RATE_HI = 8'h50;
    localparam logic [7:0] OFS_SYNTH_BASE_RATE_LO = 8'h51;
    localparam logic [7:0] OFS_SYNTH_RATE_MULT_HI = 8'h52;
    localparam logic [7:0] OFS_SYNTH_RATE_MULT_LO = 8'h53;

    // Reset values
    localparam logic [7:0] RST_SECOND_REF_PERIOD_LIMITS = 8'h55;
    localparam logic [7:0] RST_PLL_SETUP = 8'h31;
    localparam logic [15:0] RST_SYNTH_BASE_RATE = 16'h9c40;
    localparam logic [15:0] RST_SYNTH_RATE_MULT = 16'h0798;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Field positions
    localparam int TOL_LSB = 4;
    localparam int TOL_MSB = 6;
    localparam int DPLL_EN_BIT = 0;
    localparam int PHASE_ACQ_BIT = 4;

    // Period measurement timing
    localparam int CORE_CLK_PS = 8000;
    localparam int SAMPLE_CLK_MHZ = 800;
    localparam int SAMPLE_STEP_PS = 1000000 / SAMPLE_CLK_MHZ;

    // Tolerances in units of 0.01 % of the reference period
    localparam logic [63:0] TOL_SCALE = 64'h0000_0000_0000_2710;

    function automatic logic [13:0] tol_myriad(input logic [2:0] code);
        logic [13:0] t;
        t = 14'h000a;
        case (code)
            3'h0: t = 14'h000a;
            3'h1: t = 14'h0032;
            3'h2: t = 14'h0064;
            3'h3: t = 14'h00c8;
            3'h4: t = 14'h01f4;
            3'h5: t = 14'h03e8;
            3'h6: t = 14'h07d0;
            default: t = 14'h1388;
        endcase
        return t;
    endfunction : tol_myriad

    // True when cur deviates from prv by more than the coded tolerance
    function automatic logic period_excess(input logic [31:0] cur,
                                           input logic [31:0] prv,
                                           input logic [2:0] code);
        logic [31:0] diff;
        logic [63:0] lhs;
        logic [63:0] rhs;
        diff = (cur > prv) ? cur - prv : prv - cur;
        lhs = {32'h0, diff} * TOL_SCALE;
        rhs = {32'h0, prv} * {50'h0, tol_myriad(code)};
        return lhs > rhs;
    endfunction : period_excess

endpackage : ref_cfg_pkg

// file: cycle_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module cycle_monitor #(
    parameter int CNT_W = 20
) (
    input wire logic core_clk, // Core clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic second_reference, // Reference pin, asynchronous
    input wire logic [2:0] tol_code, // Tolerance selection
    output logic fail // High after an out-of-tolerance cycle
);

    // Counter must fit the 32-bit period arithmetic of the package
    if (CNT_W < 4 || CNT_W > 30) begin : g_cnt_w_check
        $error("cycle_monitor: CNT_W out of range");
    end

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic last;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] prev_period;
        logic [1:0] edges;
        logic fail;
    } mon_t;

    localparam mon_t MON_RST = '0;
    localparam logic [CNT_W-1:0] CNT_MAX = '1;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    mon_t st_r;
    mon_t st_nxt;
    logic rise;
    logic excess;

    assign rise = st_r.sync2 & ~st_r.last;
    assign excess = ref_cfg_pkg::period_excess(32'(st_r.cnt),
        32'(st_r.prev_period), tol_code);

    always_comb begin
        st_nxt = st_r;
        st_nxt.sync1 = second_reference;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.last = st_r.sync2;
        if (st_r.cnt != CNT_MAX) begin
            st_nxt.cnt = st_r.cnt + CNT_ONE;
        end
        if (rise) begin
            // Period counted in core cycles of CORE_CLK_PS each
            st_nxt.cnt = CNT_ONE;
            if (st_r.cnt == CNT_MAX) begin
                // Reference stalled: restart, coarse monitor owns this case
                st_nxt.edges = 2'h1;
            end else begin
                if (st_r.edges == 2'h2) begin
                    st_nxt.fail = excess;
                end else if (st_r.edges != 2'h0) begin
                    st_nxt.edges = 2'h2;
                end else begin
                    st_nxt.edges = 2'h1;
                end
                if (st_r.edges != 2'h0) begin
                    st_nxt.prev_period = st_r.cnt;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r <= MON_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign fail = st_r.fail;

    default clocking mon_cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_measured;
        rise && st_r.edges == 2'h2 && st_r.cnt != CNT_MAX;
    endsequence

    a_fail_on_excess: assert property (
        s_measured ##0 excess |=> fail)
        else $error("failure indicator missed an out-of-tolerance cycle");

    a_no_false_fail: assert property (
        s_measured ##0 (st_r.cnt == st_r.prev_period) |=> !fail)
        else $error("failure indicator set on an exact period match");

    a_fail_holds: assert property (
        !rise |=> $stable(fail))
        else $error("failure indicator changed without a reference edge");

endmodule : cycle_monitor

`default_nettype wire

// file: ref_monitor_dpll_synth_config.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - The three-bit tolerance field at bits 6:4 picks 0.1, 0.5, 1, 2, 5, 10, 20 or 50 percent of the reference period.
// - The cycle failure output goes high when a measured reference period falls outside the chosen tolerance.
// - The reference period is measured by counting core clock cycles, in 8 ns steps of the 125 MHz core clock.
// - The phase acquisition enable follows bit 4 of the PLL setup register, low meaning powered down.
// - The 16-bit base rate word is an unsigned frequency in hertz driven to the synthesizer.
module ref_monitor_dpll_synth_config #(
    parameter int CNT_W = 20
) (
    input wire logic core_clk, // Core clock, 125 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic [7:0] reg_addr, // Register byte address
    input wire logic reg_wr, // Write strobe, one cycle
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_rd, // Read strobe, one cycle
    output logic [7:0] reg_rdata, // Read data, valid cycle after reg_rd
    input wire logic second_reference, // Second reference input pin
    output logic second_ref_cycle_fail, // Single-cycle failure indicator
    output logic [2:0] second_ref_cycle_tolerance, // Selected tolerance
    output logic dpll_enable, // Digital PLL run enable
    output logic phase_acq_enable, // Phase acquisition power enable
    output logic [15:0] base_rate_word, // Synthesizer base rate in Hz
    output logic [15:0] rate_multiplier // Synthesizer rate multiple
);

    // Counter must fit the 32-bit period arithmetic of the package
    if (CNT_W < 4 || CNT_W > 30) begin : g_cnt_w_check
        $error("ref_monitor_dpll_synth_config: CNT_W out of range");
    end

    typedef struct packed {
        logic [7:0] limits;
        logic [7:0] pll;
        logic [15:0] base_rate;
        logic [15:0] mult;
        logic [7:0] rdata;
    } cfg_t;

    localparam cfg_t CFG_RST = '{
        limits: ref_cfg_pkg::RST_SECOND_REF_PERIOD_LIMITS,
        pll: ref_cfg_pkg::RST_PLL_SETUP,
        base_rate: ref_cfg_pkg::RST_SYNTH_BASE_RATE,
        mult: ref_cfg_pkg::RST_SYNTH_RATE_MULT,
        rdata: ref_cfg_pkg::UNMAPPED_READ
    };

    cfg_t st_r;
    cfg_t st_nxt;

    // True for the six byte addresses that hold a register
    function automatic logic is_mapped(input logic [7:0] a);
        logic hit;
        hit = 1'b0;
        case (a)
            ref_cfg_pkg::OFS_SECOND_REF_PERIOD_LIMITS,
            ref_cfg_pkg::OFS_PLL_SETUP,
            ref_cfg_pkg::OFS_SYNTH_BASE_RATE_HI,
            ref_cfg_pkg::OFS_SYNTH_BASE_RATE_LO,
            ref_cfg_pkg::OFS_SYNTH_RATE_MULT_HI,
            ref_cfg_pkg::OFS_SYNTH_RATE_MULT_LO: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction : is_mapped

    // Reserved bits are stored as written so readback shows what was set
    always_comb begin
        st_nxt = st_r;
        if (reg_wr) begin
            case (reg_addr)
                ref_cfg_pkg::OFS_SECOND_REF_PERIOD_LIMITS: begin
                    st_nxt.limits = reg_wdata;
                end
                ref_cfg_pkg::OFS_PLL_SETUP: begin
                    st_nxt.pll = reg_wdata;
                end
                ref_cfg_pkg::OFS_SYNTH_BASE_RATE_HI: begin
                    st_nxt.base_rate[15:8] = reg_wdata;
                end
                ref_cfg_pkg::OFS_SYNTH_BASE_RATE_LO: begin
                    st_nxt.base_rate[7:0] = reg_wdata;
                end
                ref_cfg_pkg::OFS_SYNTH_RATE_MULT_HI: begin
                    st_nxt.mult[15:8] = reg_wdata;
                end
                ref_cfg_pkg::OFS_SYNTH_RATE_MULT_LO: begin
                    st_nxt.mult[7:0] = reg_wdata;
                end
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                ref_cfg_pkg::OFS_SECOND_REF_PERIOD_LIMITS: begin
                    st_nxt.rdata = st_r.limits;
                end
                ref_cfg_pkg::OFS_PLL_SETUP: begin
                    st_nxt.rdata = st_r.pll;
                end
                ref_cfg_pkg::OFS_SYNTH_BASE_RATE_HI: begin
                    st_nxt.rdata = st_r.base_rate[15:8];
                end
                ref_cfg_pkg::OFS_SYNTH_BASE_RATE_LO: begin
                    st_nxt.rdata = st_r.base_rate[7:0];
                end
                ref_cfg_pkg::OFS_SYNTH_RATE_MULT_HI: begin
                    st_nxt.rdata = st_r.mult[15:8];
                end
                ref_cfg_pkg::OFS_SYNTH_RATE_MULT_LO: begin
                    st_nxt.rdata = st_r.mult[7:0];
                end
                default: begin
                    st_nxt.rdata = ref_cfg_pkg::UNMAPPED_READ;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r <= CFG_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign second_ref_cycle_tolerance =
        st_r.limits[ref_cfg_pkg::TOL_MSB:ref_cfg_pkg::TOL_LSB];
    assign dpll_enable = st_r.pll[ref_cfg_pkg::DPLL_EN_BIT];
    assign phase_acq_enable = st_r.pll[ref_cfg_pkg::PHASE_ACQ_BIT];
    assign base_rate_word = st_r.base_rate;
    assign rate_multiplier = st_r.mult;

    // Failure output is raw; masking above 400 MHz is left to software
    cycle_monitor #(
        .CNT_W(CNT_W)
    ) u_cycle_monitor (
        .core_clk(core_clk),
        .rst(rst),
        .second_reference(second_reference),
        .tol_code(second_ref_cycle_tolerance),
        .fail(second_ref_cycle_fail)
    );

    default clocking cfg_cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_wr_to(logic [7:0] a);
        reg_wr && reg_addr == a;
    endsequence

    a_dpll_follows_bit: assert property (
        s_wr_to(ref_cfg_pkg::OFS_PLL_SETUP) |=>
            dpll_enable == $past(reg_wdata[ref_cfg_pkg::DPLL_EN_BIT]))
        else $error("pll enable did not follow setup bit 0");

    a_phase_acq_bit: assert property (
        s_wr_to(ref_cfg_pkg::OFS_PLL_SETUP) |=>
            phase_acq_enable == $past(reg_wdata[ref_cfg_pkg::PHASE_ACQ_BIT]))
        else $error("phase acquisition enable did not follow bit 4");

    a_tol_field_write: assert property (
        s_wr_to(ref_cfg_pkg::OFS_SECOND_REF_PERIOD_LIMITS) |=>
            second_ref_cycle_tolerance ==
            $past(reg_wdata[ref_cfg_pkg::TOL_MSB:ref_cfg_pkg::TOL_LSB]))
        else $error("tolerance code not taken from bits 6:4");

    a_base_rate_pair: assert property (
        s_wr_to(ref_cfg_pkg::OFS_SYNTH_BASE_RATE_HI) ##1
            s_wr_to(ref_cfg_pkg::OFS_SYNTH_BASE_RATE_LO) |=>
            base_rate_word == {$past(reg_wdata, 2), $past(reg_wdata)})
        else $error("base rate word not assembled high then low");

    a_pll_readback: assert property (
        reg_rd && reg_addr == ref_cfg_pkg::OFS_PLL_SETUP && !reg_wr |=>
            reg_rdata[ref_cfg_pkg::DPLL_EN_BIT] == dpll_enable)
        else $error("pll setup readback does not match enable");

    a_tol_readback: assert property (
        reg_rd && reg_addr == ref_cfg_pkg::OFS_SECOND_REF_PERIOD_LIMITS &&
            !reg_wr |=> reg_rdata[ref_cfg_pkg::TOL_MSB:ref_cfg_pkg::TOL_LSB]
            == second_ref_cycle_tolerance)
        else $error("limits readback does not match tolerance output");

    a_base_hi_byte: assert property (
        s_wr_to(ref_cfg_pkg::OFS_SYNTH_BASE_RATE_HI) |=>
            base_rate_word[15:8] == $past(reg_wdata))
        else $error("base rate high byte not taken from its write");

    a_base_lo_byte: assert property (
        s_wr_to(ref_cfg_pkg::OFS_SYNTH_BASE_RATE_LO) |=>
            base_rate_word[7:0] == $past(reg_wdata))
        else $error("base rate low byte not taken from its write");

    // A stray write to a hole must not disturb any live setting
    a_hole_write_dropped: assert property (
        reg_wr && !is_mapped(reg_addr) |=>
            $stable(st_r.limits) && $stable(st_r.pll) &&
            $stable(st_r.base_rate) && $stable(st_r.mult))
        else $error("write to an unmapped address changed a register");

    a_cfg_idle_hold: assert property (
        !reg_wr |=> $stable(dpll_enable) && $stable(phase_acq_enable) &&
            $stable(second_ref_cycle_tolerance) && $stable(base_rate_word))
        else $error("configuration output changed without a write");

    a_hole_reads_zero: assert property (
        reg_rd && !is_mapped(reg_addr) |=>
            reg_rdata == ref_cfg_pkg::UNMAPPED_READ)
        else $error("read of an unmapped address returned nonzero data");

    a_rdata_stands: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read strobe");

endmodule : ref_monitor_dpll_synth_config

`default_nettype wire

// file: mgmt_host.sv
`timescale 1ns/1ps
`default_nettype none

module mgmt_host #(
    parameter bit REF_ABOVE_400M = 1'b0
) (
    input wire logic core_clk, // Core clock
    output logic [7:0] reg_addr, // Byte address
    output logic reg_wr, // Write strobe
    output logic [7:0] reg_wdata, // Write data
    output logic reg_rd, // Read strobe
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic cycle_fail, // Raw cycle failure flag
    output logic cycle_fail_seen // Flag as software uses it
);
    // Above 400 MHz the raw flag is noise, so software drops it
    assign cycle_fail_seen = cycle_fail & ~REF_ABOVE_400M;

    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Callers keep periods long enough for the code they pick
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        // Idle bus shows junk so stale values cannot pass
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr

    // Two bytes on consecutive edges, as a 16-bit update would arrive
    task automatic wr2(input logic [7:0] a, input logic [7:0] d0,
                       input logic [7:0] d1);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d0;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_addr = a + 8'h01;
        reg_wdata = d1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d1;
    endtask : wr2

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask : rd
endmodule : mgmt_host

`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic core_clk;
    logic rst;
    logic ref_r;
    logic [7:0] addr, wdata, rdata, rv;
    logic wr, rd, fail_raw, fail_seen, dpll_o, pacq_o;
    logic [2:0] tol_o;
    logic [15:0] base_o, mult_o;
    int fails = 0;
    int cmp_count = 0;
    int seed, cyc = 0, t_last = 0, p1, p2, nedge, b, dm;
    logic [2:0] cur_tol = 3'h5;
    int tol_tab [8] = '{10, 50, 100, 200, 500, 1000, 2000, 5000};
    logic [7:0] ofs [6] = '{8'h4c, 8'h4f, 8'h50, 8'h51, 8'h52, 8'h53};
    logic [7:0] dflt [6] = '{8'h55, 8'h31, 8'h9c, 8'h40, 8'h07, 8'h98};
    logic [7:0] sh [6];
    logic [15:0] rates [7] = '{16'h1388, 16'h186a, 16'h1f40, 16'h2710,
                               16'h30d4, 16'h61a8, 16'h9c40};

    mgmt_host host (.core_clk(core_clk), .reg_addr(addr), .reg_wr(wr),
        .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata),
        .cycle_fail(fail_raw), .cycle_fail_seen(fail_seen));

    ref_monitor_dpll_synth_config #(.CNT_W(20)) dut (.core_clk(core_clk),
        .rst(rst), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
        .reg_rd(rd), .reg_rdata(rdata), .second_reference(ref_r),
        .second_ref_cycle_fail(fail_raw),
        .second_ref_cycle_tolerance(tol_o), .dpll_enable(dpll_o),
        .phase_acq_enable(pacq_o), .base_rate_word(base_o),
        .rate_multiplier(mult_o));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge core_clk) cyc <= cyc + 1;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask : rd_chk

    task automatic out_chk();
        chk({13'h0, tol_o}, {13'h0, sh[0][6:4]});
        chk({15'h0, dpll_o}, {15'h0, sh[1][0]});
        chk({15'h0, pacq_o}, {15'h0, sh[1][4]});
        chk(base_o, {sh[2], sh[3]});
        chk(mult_o, {sh[4], sh[5]});
    endtask : out_chk

    task automatic reset_chk();
        sh = dflt;
        nedge = 0;
        for (int i = 0; i < 6; i++) begin
            rd_chk(ofs[i], sh[i]);
        end
        out_chk();
        chk({15'h0, fail_seen}, 16'h0000);
    endtask : reset_chk

    function automatic logic exp_fail(input int cur, input int prv);
        longint diff;
        diff = (cur > prv) ? cur - prv : prv - cur;
        return diff * 10000 > longint'(prv) * tol_tab[cur_tol];
    endfunction : exp_fail

    // Raises an edge, checks the period that just ended, then waits p
    task automatic ref_per(input int p);
        ref_r = 1'b1;
        nedge++;
        p2 = p1;
        p1 = cyc - t_last;
        t_last = cyc;
        repeat (7) @(negedge core_clk);
        if (nedge >= 3) begin
            chk({15'h0, fail_seen}, {15'h0, exp_fail(p1, p2)});
        end
        repeat (p / 2 - 7) @(negedge core_clk);
        ref_r = 1'b0;
        repeat (p - p / 2) @(negedge core_clk);
    endtask : ref_per

    task automatic close_out();
        $display("fails=%0d cmp_count=%0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (60000) @(posedge core_clk);
        fails++;
        close_out();
    end

    initial begin
        seed = 32'hd6fd;
        rst = 1'b1;
        ref_r = 1'b0;
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        reset_chk();
        for (int r = 0; r < 8; r++) begin
            for (int i = 0; i < 6; i++) begin
                rv = $random(seed);
                if (i == 1 && r < 2) rv = {8{r[0]}};
                if (i == 2 && r < 7) rv = rates[r][15:8];
                if (i == 3 && r < 7) rv = rates[r][7:0];
                host.wr(ofs[i], rv);
                sh[i] = rv;
                rd_chk(ofs[i], rv);
            end
            out_chk();
            // Unmapped hole: write dropped, reads zero
            host.wr(8'h4d, rv);
            rd_chk(8'h4d, 8'h00);
            out_chk();
            // Back-to-back byte pair for the 16-bit base rate
            rv = $random(seed);
            host.wr2(8'h50, rv, ~rv);
            sh[2] = rv;
            sh[3] = ~rv;
            out_chk();
        end
        for (int c = 0; c < 8; c++) begin
            rv = $random(seed);
            rv[6:4] = c[2:0];
            host.wr(8'h4c, rv);
            cur_tol = c[2:0];
            b = 200 + ($unsigned($random(seed)) % 50);
            dm = b * tol_tab[c] / 10000;
            ref_per(b);
            ref_per(b);
            ref_per(b + dm);
            ref_per(b);
            ref_per(b + dm + 1);
            ref_per(b - dm - 2 + ($unsigned($random(seed)) % (2 * dm + 5)));
            ref_per(b);
        end
        rst = 1'b1;
        cur_tol = 3'h5;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        reset_chk();
        close_out();
    end
endmodule : testbench

`default_nettype wire
